// ---- dv/crf_core_properties.sv ----
// Concurrent checks on the program counter, flag and address outputs
`timescale 1ns/100ps
module crf_core_props (
   input wire i_clk,
   input wire i_rstn,
   input wire i_exc_start,
   input wire i_pc_load,
   input wire [15:0] i_pc_value,
   input wire i_pc_step,
   input wire [15:0] i_addr_in,
   input wire o_vec_req,
   input wire [15:0] o_program_counter,
   input wire [7:0] o_condition_flags,
   input wire [15:0] o_flags_push_word,
   input wire [15:0] o_word_addr,
   input wire o_irq_masked,
   input wire o_ready
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_pc_even; o_program_counter[0] == 1'b0; endproperty
   a_pc_even: assert property (p_pc_even) else $error("Odd program counter");
   property p_pc_load;
      o_ready && i_pc_load && !i_pc_step |=> o_program_counter == ($past(i_pc_value) & 16'hfffe);
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("Program counter load wrong");
   property p_pc_step;
      o_ready && i_pc_step && !i_pc_load |=> o_program_counter == $past(o_program_counter) + 16'h0002;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("Program counter step wrong");
   property p_word_addr; o_ready && $past(o_ready) |-> o_word_addr == ($past(i_addr_in) & 16'hfffe); endproperty
   a_word_addr: assert property (p_word_addr) else $error("Word address not aligned");
   property p_exc_mask; o_ready && i_exc_start |-> ##[1:3] o_condition_flags[7]; endproperty
   a_exc_mask: assert property (p_exc_mask) else $error("Mask not set at exception");
   property p_irq_follow; o_ready && o_condition_flags[7] |-> ##[0:1] o_irq_masked; endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("Interrupts not masked");
   property p_vec_phase; o_vec_req |-> !o_ready && o_condition_flags[7]; endproperty
   a_vec_phase: assert property (p_vec_phase) else $error("Vector phase state wrong");
   property p_push_double; o_flags_push_word[15:8] == o_flags_push_word[7:0]; endproperty
   a_push_double: assert property (p_push_double) else $error("Pushed flag copies differ");
endmodule
bind crf_core crf_core_props u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_exc_start(i_exc_start),
   .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_pc_step(i_pc_step), .i_addr_in(i_addr_in),
   .o_vec_req(o_vec_req), .o_program_counter(o_program_counter), .o_condition_flags(o_condition_flags),
   .o_flags_push_word(o_flags_push_word), .o_word_addr(o_word_addr), .o_irq_masked(o_irq_masked),
   .o_ready(o_ready));

// ---- dv/testbench.sv ----
// Directed testbench for the register file and condition flags
`timescale 1ns/100ps
`include "crf_defines.vh"
module testbench;
   reg i_clk = 1'b0;
   reg i_rstn = 1'b0;
   reg i_op_valid = 1'b0;
   reg [4:0] i_op = 5'h00;
   reg i_word = 1'b0;
   reg [1:0] i_dst_sel = 2'h0;
   reg [2:0] i_dst = 3'h0;
   reg [1:0] i_src_sel = 2'h0;
   reg [2:0] i_src = 3'h0;
   reg [15:0] i_imm = 16'h0000;
   reg [2:0] i_bit_idx = 3'h0;
   reg i_bit_inv = 1'b0;
   reg i_keep_flags = 1'b0;
   reg i_exc_start = 1'b0;
   reg i_pc_load = 1'b0;
   reg [15:0] i_pc_value = 16'h0000;
   reg i_pc_step = 1'b0;
   reg [15:0] i_vec_data = 16'h1235;
   reg [15:0] i_addr_in = 16'h0000;
   reg [2:0] i_rd_reg = 3'h0;
   reg [3:0] i_cond = 4'h0;
   wire o_vec_req, o_cond_true, o_irq_masked, o_ready;
   wire [15:0] o_program_counter, o_flags_push_word, o_stack_pointer, o_word_addr, o_rd_word;
   wire [7:0] o_condition_flags;
   integer mismatches;
   integer checks_done;
   integer i;
   reg prev;
   crf_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op(i_op), .i_word(i_word),
      .i_dst_sel(i_dst_sel), .i_dst(i_dst), .i_src_sel(i_src_sel), .i_src(i_src), .i_imm(i_imm),
      .i_bit_idx(i_bit_idx), .i_bit_inv(i_bit_inv), .i_keep_flags(i_keep_flags), .i_exc_start(i_exc_start),
      .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_pc_step(i_pc_step), .i_vec_data(i_vec_data),
      .i_addr_in(i_addr_in), .i_rd_reg(i_rd_reg), .i_cond(i_cond), .o_vec_req(o_vec_req),
      .o_program_counter(o_program_counter), .o_condition_flags(o_condition_flags),
      .o_flags_push_word(o_flags_push_word), .o_stack_pointer(o_stack_pointer), .o_word_addr(o_word_addr),
      .o_rd_word(o_rd_word), .o_cond_true(o_cond_true), .o_irq_masked(o_irq_masked), .o_ready(o_ready));
   always #20 i_clk = ~i_clk;
   task stop_test;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp, input [15:0] mask, input string m);
      begin
         checks_done = checks_done + 1;
         if ((got & mask) !== (exp & mask)) begin
            mismatches = mismatches + 1;
            $display("BAD at %0t: %s got %h expected %h", $time, m, got, exp);
         end
      end
   endtask
   task chkf(input [7:0] e, input [7:0] m);
      begin
         #1;
         chk({8'h00, o_condition_flags}, {8'h00, e}, {8'h00, m}, "flags");
         @(posedge i_clk);
      end
   endtask
   // Bounded wait for ready; an op is taken at the first edge that sees ready high
   task wait_ready;
      integer n;
      begin
         n = 0;
         @(posedge i_clk);
         while (o_ready !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge i_clk);
         end
         if (o_ready !== 1'b1) begin
            mismatches = mismatches + 1;
            $display("BAD at %0t: ready timeout", $time);
            stop_test;
         end
      end
   endtask
   // No forwarding in the core, so each op is followed by idle cycles
   task op_do(input [4:0] op, input w, input [1:0] ds, input [2:0] d, input [1:0] ss, input [15:0] imm,
      input [2:0] bi);
      begin
         @(posedge i_clk);
         i_op <= op;
         i_word <= w;
         i_dst_sel <= ds;
         i_dst <= d;
         i_src_sel <= ss;
         i_imm <= imm;
         i_bit_idx <= bi;
         i_op_valid <= 1'b1;
         wait_ready;
         i_op_valid <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask
   task mov(input w, input [1:0] ds, input [2:0] d, input [15:0] imm);
      op_do(`CRF_OP_MOV, w, ds, d, 2'h3, imm, 3'h0);
   endtask
   task rd(input [2:0] r, input [15:0] exp, input [15:0] mask);
      begin
         @(posedge i_clk);
         i_rd_reg <= r;
         repeat (3) @(posedge i_clk);
         #1;
         chk(o_rd_word, exp, mask, "reg");
      end
   endtask
   // Byte operands are doubled so either immediate lane gives the same byte
   task arith(input [4:0] op, input w, input [15:0] a, input [15:0] b, input [15:0] res, input [7:0] fm,
      input [7:0] fe);
      begin
         mov(w, w ? 2'h2 : 2'h1, 3'h0, w ? a : {a[7:0], a[7:0]});
         op_do(op, w, w ? 2'h2 : 2'h1, 3'h0, 2'h3, w ? b : {b[7:0], b[7:0]}, 3'h0);
         rd(3'h0, res, w ? 16'hffff : 16'h00ff);
         chkf(fe, fm);
      end
   endtask
   initial begin
      mismatches = 0;
      checks_done = 0;
      repeat (8) @(posedge i_clk);
      chk({15'h0, o_vec_req}, 16'h1, 16'h1, "vector request");
      i_rstn <= 1'b1;
      wait_ready;
      #1;
      chk(o_program_counter, 16'h1234, 16'hffff, "vector");
      chk({15'h0, o_irq_masked}, 16'h1, 16'h1, "mask");
      chk({15'h0, o_vec_req}, 16'h0, 16'h1, "vector request");
      chkf(8'h80, 8'h80);
      $display("Test reset done");
      mov(1'b1, 2'h2, 3'h7, 16'hfff0);
      mov(1'b1, 2'h2, 3'h1, 16'h1234);
      mov(1'b0, 2'h0, 3'h1, 16'habab);
      mov(1'b0, 2'h1, 3'h1, 16'hcdcd);
      rd(3'h1, 16'habcd, 16'hffff);
      rd(3'h7, 16'hfff0, 16'hffff);
      chk(o_stack_pointer, 16'hfff0, 16'hffff, "sp");
      $display("Test registers done");
      arith(`CRF_OP_ADD, 1'b0, 16'h08, 16'h08, 16'h10, 8'h2f, 8'h20);
      arith(`CRF_OP_ADD, 1'b0, 16'h7f, 16'h01, 16'h80, 8'h2f, 8'h2a);
      arith(`CRF_OP_ADD, 1'b0, 16'hff, 16'h01, 16'h00, 8'h2f, 8'h25);
      arith(`CRF_OP_SUB, 1'b0, 16'h10, 16'h01, 16'h0f, 8'h2f, 8'h20);
      arith(`CRF_OP_CMP, 1'b0, 16'h00, 16'h01, 16'h00, 8'h2f, 8'h29);
      arith(`CRF_OP_NEG, 1'b0, 16'h01, 16'h00, 16'hff, 8'h2f, 8'h29);
      arith(`CRF_OP_ADD, 1'b1, 16'h0800, 16'h0800, 16'h1000, 8'h2f, 8'h20);
      arith(`CRF_OP_SUB, 1'b1, 16'h1000, 16'h0001, 16'h0fff, 8'h2f, 8'h20);
      arith(`CRF_OP_SHL, 1'b0, 16'h81, 16'h00, 16'h02, 8'h0d, 8'h01);
      arith(`CRF_OP_ADD, 1'b0, 16'h09, 16'h08, 16'h11, 8'h21, 8'h20);
      op_do(`CRF_OP_DAA, 1'b0, 2'h1, 3'h0, 2'h1, 16'h0000, 3'h0);
      rd(3'h0, 16'h0017, 16'h00ff);
      $display("Test arithmetic done");
      mov(1'b0, 2'h1, 3'h2, 16'h0000);
      for (i = 0; i < 8; i = i + 1) op_do(`CRF_OP_BSET, 1'b0, 2'h1, 3'h2, 2'h1, 16'h0000, i[2:0]);
      rd(3'h2, 16'h00ff, 16'h00ff);
      op_do(`CRF_OP_BCLR, 1'b0, 2'h1, 3'h2, 2'h1, 16'h0000, 3'h3);
      rd(3'h2, 16'h00f7, 16'h00ff);
      op_do(`CRF_OP_BLD, 1'b0, 2'h1, 3'h2, 2'h1, 16'h0000, 3'h3);
      chkf(8'h00, 8'h01);
      i_bit_inv <= 1'b1;
      op_do(`CRF_OP_BLD, 1'b0, 2'h1, 3'h2, 2'h1, 16'h0000, 3'h3);
      chkf(8'h01, 8'h01);
      i_bit_inv <= 1'b0;
      $display("Test bits done");
      op_do(`CRF_OP_LOAD_CTRL, 1'b0, 2'h1, 3'h0, 2'h3, 16'h00c5, 3'h0);
      chkf(8'hc5, 8'hff);
      op_do(`CRF_OP_AND_CTRL, 1'b0, 2'h1, 3'h0, 2'h3, 16'h0000, 3'h0);
      chkf(8'h00, 8'hff);
      op_do(`CRF_OP_OR_CTRL, 1'b0, 2'h1, 3'h0, 2'h3, 16'h0050, 3'h0);
      chkf(8'h50, 8'hff);
      op_do(`CRF_OP_XOR_CTRL, 1'b0, 2'h1, 3'h0, 2'h3, 16'h00ff, 3'h0);
      chkf(8'haf, 8'hff);
      chk(o_flags_push_word, 16'hafaf, 16'hffff, "push");
      op_do(`CRF_OP_POPC, 1'b0, 2'h1, 3'h0, 2'h3, 16'h1234, 3'h0);
      chkf(8'h12, 8'hff);
      i_keep_flags <= 1'b1;
      arith(`CRF_OP_ADD, 1'b0, 16'hff, 16'h01, 16'h00, 8'hff, 8'h12);
      i_keep_flags <= 1'b0;
      @(posedge i_clk);
      i_exc_start <= 1'b1;
      @(posedge i_clk);
      i_exc_start <= 1'b0;
      repeat (3) @(posedge i_clk);
      chkf(8'h92, 8'hff);
      $display("Test control flags done");
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge i_clk);
         i_cond <= {i[2:0], 1'b0};
         repeat (3) @(posedge i_clk);
         prev = o_cond_true;
         i_cond <= {i[2:0], 1'b1};
         repeat (3) @(posedge i_clk);
         chk({15'h0, o_cond_true ^ prev}, 16'h1, 16'h1, "cond");
      end
      @(posedge i_clk);
      i_pc_value <= 16'h4567;
      i_pc_load <= 1'b1;
      i_addr_in <= 16'h0fff;
      @(posedge i_clk);
      i_pc_load <= 1'b0;
      i_pc_step <= 1'b1;
      @(posedge i_clk);
      i_pc_step <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk(o_program_counter, 16'h4568, 16'hffff, "pc");
      chk(o_word_addr, 16'h0ffe, 16'hffff, "addr");
      $display("Test branch and pc done");
      stop_test;
   end
endmodule

// ---- logic/crf_core.v ----
// CPU architectural state: general registers, program counter and condition flags
`timescale 1ns/100ps
`include "crf_defines.vh"
module crf_core (
   input wire i_clk,
   input wire i_rstn,
   input wire i_op_valid,
   input wire [4:0] i_op,
   input wire i_word,
   input wire [1:0] i_dst_sel,
   input wire [2:0] i_dst,
   input wire [1:0] i_src_sel,
   input wire [2:0] i_src,
   input wire [15:0] i_imm,
   input wire [2:0] i_bit_idx,
   input wire i_bit_inv,
   input wire i_keep_flags,
   input wire i_exc_start,
   input wire i_pc_load,
   input wire [15:0] i_pc_value,
   input wire i_pc_step,
   input wire [15:0] i_vec_data,
   input wire [15:0] i_addr_in,
   input wire [2:0] i_rd_reg,
   input wire [3:0] i_cond,
   output reg o_vec_req,
   output reg [15:0] o_program_counter,
   output reg [7:0] o_condition_flags,
   output reg [15:0] o_flags_push_word,
   output reg [15:0] o_stack_pointer,
   output reg [15:0] o_word_addr,
   output reg [15:0] o_rd_word,
   output reg o_cond_true,
   output reg o_irq_masked,
   output reg o_ready
);
   // Operand source select: register byte high, byte low, word, immediate
   localparam [1:0] SEL_HI = 2'h0;
   localparam [1:0] SEL_LO = 2'h1;
   localparam [1:0] SEL_WORD = 2'h2;
   localparam [1:0] SEL_IMM = 2'h3;
   reg rst_s1_r;
   reg rst_r;
   reg sp_sel_r;
   reg [1:0] state_r, state_nxt;
   reg [15:0] pc_r, pc_nxt;
   reg [7:0] ccr_r, ccr_nxt;
   reg we_hi, we_lo;
   reg [15:0] wdata, res;
   reg [15:0] a, b;
   reg [16:0] sum;
   reg [12:0] sum12;
   reg [4:0] sum4;
   reg cin, is_sub, arith, bitv;
   reg [7:0] dadj;
   reg flag_n, flag_z, flag_v, flag_c;
   wire [15:0] rd_a, rd_b;
   wire [2:0] raddr_b;
   // Reset release through two flops; assertion stays asynchronous
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_r <= rst_s1_r;
      end
   end
   // Port b reads the source or, when idle, the debug read register
   assign raddr_b = i_op_valid ? i_src : i_rd_reg;
   crf_gpr_mem u_gpr (
      .i_clk(i_clk),
      .i_we_hi(we_hi),
      .i_we_lo(we_lo),
      .i_waddr(i_dst),
      .i_wdata(wdata),
      .i_raddr_a(i_dst),
      .i_raddr_b(raddr_b),
      .o_rdata_a(rd_a),
      .o_rdata_b(rd_b)
   );
   // Operands are taken from the register read ports one cycle after request
   reg op_v_r;
   reg [4:0] op_r;
   reg word_r;
   reg [1:0] dsel_r, ssel_r;
   reg [2:0] dst_r;
   reg [15:0] imm_r;
   reg [2:0] bidx_r;
   reg binv_r;
   reg keep_r;
   always @(posedge i_clk or negedge rst_r) begin
      if (!rst_r) begin
         op_v_r <= 1'b0;
         op_r <= 5'h00;
         word_r <= 1'b0;
         dsel_r <= 2'h0;
         ssel_r <= 2'h0;
         dst_r <= 3'h0;
         imm_r <= 16'h0000;
         bidx_r <= 3'h0;
         binv_r <= 1'b0;
         keep_r <= 1'b0;
         sp_sel_r <= 1'b0;
      end else begin
         op_v_r <= i_op_valid && (state_r == `CRF_ST_RUN);
         op_r <= i_op;
         word_r <= i_word;
         dsel_r <= i_dst_sel;
         ssel_r <= i_src_sel;
         dst_r <= i_dst;
         imm_r <= i_imm;
         bidx_r <= i_bit_idx;
         binv_r <= i_bit_inv;
         keep_r <= i_keep_flags;
         sp_sel_r <= !i_op_valid && (i_rd_reg == `CRF_SP_INDEX);
      end
   end
   // Hazard: write happens in the execute cycle, so read-after-write needs one idle cycle
   always @* begin
      case (dsel_r)
         SEL_HI: a = {8'h00, rd_a[15:8]};
         SEL_LO: a = {8'h00, rd_a[7:0]};
         default: a = rd_a;
      endcase
      case (ssel_r)
         SEL_HI: b = {8'h00, rd_b[15:8]};
         SEL_LO: b = {8'h00, rd_b[7:0]};
         SEL_IMM: b = imm_r;
         default: b = rd_b;
      endcase
      if (!word_r) begin
         b = {8'h00, b[7:0]};
      end
   end
   always @* begin
      ccr_nxt = ccr_r;
      pc_nxt = pc_r;
      state_nxt = state_r;
      we_hi = 1'b0;
      we_lo = 1'b0;
      wdata = 16'h0000;
      res = 16'h0000;
      sum = 17'h00000;
      sum12 = 13'h0000;
      sum4 = 5'h00;
      cin = 1'b0;
      is_sub = 1'b0;
      arith = 1'b0;
      bitv = a[bidx_r] ^ binv_r;
      dadj = 8'h00;
      flag_c = ccr_r[`CRF_FLAG_C];
      flag_v = 1'b0;
      case (state_r)
         `CRF_ST_VEC: begin
            pc_nxt = {i_vec_data[15:1], 1'b0};
            state_nxt = `CRF_ST_RUN;
         end
         default: begin
            if (i_pc_load) begin
               pc_nxt = {i_pc_value[15:1], 1'b0};
            end else if (i_pc_step) begin
               pc_nxt = pc_r + 16'h0002;
            end
         end
      endcase
      if (op_v_r) begin
         case (op_r)
            `CRF_OP_ADD, `CRF_OP_ADDX, `CRF_OP_SUB, `CRF_OP_SUBX, `CRF_OP_CMP, `CRF_OP_NEG: begin
               arith = 1'b1;
               is_sub = (op_r != `CRF_OP_ADD) && (op_r != `CRF_OP_ADDX);
               cin = ((op_r == `CRF_OP_ADDX) || (op_r == `CRF_OP_SUBX)) ? ccr_r[`CRF_FLAG_C] : 1'b0;
            end
            default: arith = 1'b0;
         endcase
      end
      if (arith) begin
         // Subtraction done as a + ~b + 1 - borrow; NEG is 0 - dst
         if (op_r == `CRF_OP_NEG) begin
            sum = {1'b0, 16'h0000} + {1'b0, ~a} + 17'h00001;
            sum12 = {1'b0, 12'h000} + {1'b0, ~a[11:0]} + 13'h0001;
            sum4 = {1'b0, 4'h0} + {1'b0, ~a[3:0]} + 5'h01;
         end else if (is_sub) begin
            sum = {1'b0, a} + {1'b0, ~b} + {16'h0000, ~cin};
            sum12 = {1'b0, a[11:0]} + {1'b0, ~b[11:0]} + {12'h000, ~cin};
            sum4 = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~cin};
         end else begin
            sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
            sum12 = {1'b0, a[11:0]} + {1'b0, b[11:0]} + {12'h000, cin};
            sum4 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         end
         res = word_r ? sum[15:0] : {8'h00, sum[7:0]};
         if (word_r) begin
            ccr_nxt[`CRF_FLAG_H] = sum12[12] ^ is_sub;
            flag_c = sum[16] ^ is_sub;
            flag_v = is_sub ? ((a[15] ^ b[15]) & (a[15] ^ sum[15])) : (~(a[15] ^ b[15]) & (a[15] ^ sum[15]));
         end else begin
            ccr_nxt[`CRF_FLAG_H] = sum4[4] ^ is_sub;
            flag_c = (op_r == `CRF_OP_NEG) ? (a[7:0] != 8'h00) : (sum[8] ^ a[8] ^ b[8]);
            flag_v = (op_r == `CRF_OP_NEG) ? (a[7:0] == 8'h80) :
               (is_sub ? ((a[7] ^ b[7]) & (a[7] ^ sum[7])) : (~(a[7] ^ b[7]) & (a[7] ^ sum[7])));
         end
         if (op_r != `CRF_OP_CMP) begin
            wdata = res;
         end
      end
      flag_n = word_r ? res[15] : res[7];
      flag_z = word_r ? (res == 16'h0000) : (res[7:0] == 8'h00);
      if (op_v_r) begin
         case (op_r)
            `CRF_OP_AND, `CRF_OP_OR, `CRF_OP_XOR, `CRF_OP_MOV: begin
               res = (op_r == `CRF_OP_AND) ? (a & b) : (op_r == `CRF_OP_OR) ? (a | b) :
                  (op_r == `CRF_OP_XOR) ? (a ^ b) : b;
               wdata = res;
            end
            `CRF_OP_SHL: begin
               res = {8'h00, a[6:0], binv_r & ccr_r[`CRF_FLAG_C]};
               flag_c = a[7];
               wdata = res;
            end
            `CRF_OP_SHR: begin
               res = {8'h00, binv_r & ccr_r[`CRF_FLAG_C], a[7:1]};
               flag_c = a[0];
               wdata = res;
            end
            `CRF_OP_DAA, `CRF_OP_DAS: begin
               // Each nibble is one digit; half-carry and carry pick the correction
               if (ccr_r[`CRF_FLAG_H] || (a[3:0] > 4'h9)) begin
                  dadj[3:0] = 4'h6;
               end
               if (ccr_r[`CRF_FLAG_C] || (a[7:0] > 8'h99)) begin
                  dadj[7:4] = 4'h6;
               end
               res = (op_r == `CRF_OP_DAA) ? {8'h00, a[7:0] + dadj} : {8'h00, a[7:0] - dadj};
               flag_c = (op_r == `CRF_OP_DAA) ? (dadj[7:4] != 4'h0) : ccr_r[`CRF_FLAG_C];
               wdata = res;
            end
            `CRF_OP_BSET, `CRF_OP_BCLR, `CRF_OP_BNOT, `CRF_OP_BST: begin
               res = a;
               res[bidx_r] = (op_r == `CRF_OP_BSET) ? 1'b1 : (op_r == `CRF_OP_BCLR) ? 1'b0 :
                  (op_r == `CRF_OP_BNOT) ? ~a[bidx_r] : (ccr_r[`CRF_FLAG_C] ^ binv_r);
               wdata = res;
            end
            default: begin
            end
         endcase
         case (op_r)
            `CRF_OP_AND, `CRF_OP_OR, `CRF_OP_XOR, `CRF_OP_MOV, `CRF_OP_SHL, `CRF_OP_SHR,
            `CRF_OP_DAA, `CRF_OP_DAS: begin
               flag_n = word_r ? res[15] : res[7];
               flag_z = word_r ? (res == 16'h0000) : (res[7:0] == 8'h00);
            end
            default: begin
            end
         endcase
         // Result written to the selected lanes; address regs use word lanes
         case (op_r)
            `CRF_OP_ADD, `CRF_OP_ADDX, `CRF_OP_SUB, `CRF_OP_SUBX, `CRF_OP_NEG, `CRF_OP_AND, `CRF_OP_OR,
            `CRF_OP_XOR, `CRF_OP_MOV, `CRF_OP_SHL, `CRF_OP_SHR, `CRF_OP_DAA, `CRF_OP_DAS,
            `CRF_OP_BSET, `CRF_OP_BCLR, `CRF_OP_BNOT, `CRF_OP_BST: begin
               we_hi = (dsel_r != SEL_LO);
               we_lo = (dsel_r != SEL_HI);
               if (dsel_r == SEL_HI) begin
                  wdata = {wdata[7:0], 8'h00};
               end
            end
            `CRF_OP_SPADJ, `CRF_OP_ADDS: begin
               // Word-only arithmetic on address registers, flags untouched
               we_hi = 1'b1;
               we_lo = 1'b1;
               wdata = rd_a + imm_r;
            end
            default: begin
            end
         endcase
         // Flag write-back
         case (op_r)
            `CRF_OP_ADD, `CRF_OP_ADDX, `CRF_OP_SUB, `CRF_OP_SUBX, `CRF_OP_CMP, `CRF_OP_NEG,
            `CRF_OP_SHL, `CRF_OP_SHR, `CRF_OP_DAA, `CRF_OP_DAS: begin
               ccr_nxt[`CRF_FLAG_N] = flag_n;
               ccr_nxt[`CRF_FLAG_Z] = ((op_r == `CRF_OP_ADDX) || (op_r == `CRF_OP_SUBX)) ?
                  (flag_z & ccr_r[`CRF_FLAG_Z]) : flag_z;
               ccr_nxt[`CRF_FLAG_V] = flag_v;
               ccr_nxt[`CRF_FLAG_C] = flag_c;
            end
            `CRF_OP_AND, `CRF_OP_OR, `CRF_OP_XOR, `CRF_OP_MOV: begin
               ccr_nxt[`CRF_FLAG_N] = flag_n;
               ccr_nxt[`CRF_FLAG_Z] = flag_z;
               ccr_nxt[`CRF_FLAG_V] = 1'b0;
            end
            `CRF_OP_BLD: ccr_nxt[`CRF_FLAG_C] = bitv;
            `CRF_OP_BAND: ccr_nxt[`CRF_FLAG_C] = ccr_r[`CRF_FLAG_C] & bitv;
            `CRF_OP_BOR: ccr_nxt[`CRF_FLAG_C] = ccr_r[`CRF_FLAG_C] | bitv;
            `CRF_OP_BXOR: ccr_nxt[`CRF_FLAG_C] = ccr_r[`CRF_FLAG_C] ^ bitv;
            `CRF_OP_BTST: ccr_nxt[`CRF_FLAG_Z] = ~a[bidx_r];
            `CRF_OP_LOAD_CTRL: ccr_nxt = b[7:0];
            `CRF_OP_AND_CTRL: ccr_nxt = ccr_r & imm_r[7:0];
            `CRF_OP_OR_CTRL: ccr_nxt = ccr_r | imm_r[7:0];
            `CRF_OP_XOR_CTRL: ccr_nxt = ccr_r ^ imm_r[7:0];
            `CRF_OP_POPC: ccr_nxt = imm_r[15:8];
            default: begin
            end
         endcase
         if (keep_r && (op_r != `CRF_OP_LOAD_CTRL) && (op_r != `CRF_OP_AND_CTRL) && (op_r != `CRF_OP_OR_CTRL) &&
            (op_r != `CRF_OP_XOR_CTRL) && (op_r != `CRF_OP_POPC)) begin
            ccr_nxt = ccr_r;
         end
      end
      // Exception entry sets the mask bit over any flag write in the same cycle; other flag bits still take the op's write
      if (i_exc_start && (state_r == `CRF_ST_RUN)) begin
         ccr_nxt[`CRF_FLAG_MASK] = 1'b1;
      end
   end
   always @(posedge i_clk or negedge rst_r) begin
      if (!rst_r) begin
         state_r <= `CRF_ST_VEC;
         pc_r <= `CRF_RESET_VECTOR;
         ccr_r <= `CRF_RESET_FLAGS;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         ccr_r <= ccr_nxt;
      end
   end
   // Branch condition evaluation from N, Z, V, C
   reg cond;
   always @* begin
      case (i_cond[3:1])
         3'h0: cond = 1'b1;
         3'h1: cond = ~(ccr_r[`CRF_FLAG_C] | ccr_r[`CRF_FLAG_Z]);
         3'h2: cond = ~ccr_r[`CRF_FLAG_C];
         3'h3: cond = ~ccr_r[`CRF_FLAG_Z];
         3'h4: cond = ~ccr_r[`CRF_FLAG_V];
         3'h5: cond = ~ccr_r[`CRF_FLAG_N];
         3'h6: cond = ~(ccr_r[`CRF_FLAG_N] ^ ccr_r[`CRF_FLAG_V]);
         default: cond = ~(ccr_r[`CRF_FLAG_Z] | (ccr_r[`CRF_FLAG_N] ^ ccr_r[`CRF_FLAG_V]));
      endcase
      cond = cond ^ i_cond[0];
   end
   always @(posedge i_clk or negedge rst_r) begin
      if (!rst_r) begin
         o_vec_req <= 1'b1;
         o_program_counter <= 16'h0000;
         o_condition_flags <= `CRF_RESET_FLAGS;
         o_flags_push_word <= {`CRF_RESET_FLAGS, `CRF_RESET_FLAGS};
         o_stack_pointer <= 16'h0000;
         o_word_addr <= 16'h0000;
         o_rd_word <= 16'h0000;
         o_cond_true <= 1'b0;
         o_irq_masked <= 1'b1;
         o_ready <= 1'b0;
      end else begin
         o_vec_req <= (state_nxt == `CRF_ST_VEC);
         o_program_counter <= {pc_nxt[15:1], 1'b0};
         o_condition_flags <= ccr_nxt;
         o_flags_push_word <= {ccr_nxt, ccr_nxt};
         if (sp_sel_r) begin // Select delayed to match the registered read port
            o_stack_pointer <= rd_b;
         end
         o_word_addr <= {i_addr_in[15:1], 1'b0};
         o_rd_word <= rd_b;
         o_cond_true <= cond;
         o_irq_masked <= ccr_nxt[`CRF_FLAG_MASK];
         o_ready <= (state_nxt == `CRF_ST_RUN);
      end
   end
endmodule

// ---- logic/crf_defines.vh ----
// Constants for the CPU register file and condition flags
// Summary of operation
// - Sixteen byte registers, also paired as eight word registers.
// - Data access whole word or either byte; address access always whole word.
// - Eighth word register is the stack pointer, used implicitly by hardware.
// - Program counter is 16 bits; its lowest bit always reads zero.
// - Flag bit 7 masks interrupts; set at exception start; software writable.
// - Bits 6 and 4 are user bits, reached only by control-register instructions.
// - Half-carry from bit 3 on byte add, addx, sub, subx, compare, negate.
// - Half-carry from bit 11 on word add, subtract, compare.
// - Decimal adjust reads the half-carry flag.
// - Negative flag copies the result sign bit.
// - Zero flag set when result is zero.
// - Overflow flag set on arithmetic overflow.
// - Carry records add carry, subtract borrow, shifted-out bit.
// - Bit instructions use carry as a one-bit accumulator.
// - Branch conditions come from N, Z, V, C; some ops keep flags.
// - Reset loads program counter from vector word at zero, sets mask.
// - Single-bit operations select bit 0 to 7 of a byte.
// - Decimal adjust treats each nibble as one decimal digit.
// - Word accesses force address bit 0 to zero.
// - Flag push writes two copies; restore ignores low byte.
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH
`define CRF_FLAG_MASK 7
`define CRF_FLAG_U6 6
`define CRF_FLAG_H 5
`define CRF_FLAG_U4 4
`define CRF_FLAG_N 3
`define CRF_FLAG_Z 2
`define CRF_FLAG_V 1
`define CRF_FLAG_C 0
`define CRF_SP_INDEX 3'h7
`define CRF_RESET_VECTOR 16'h0000
`define CRF_RESET_FLAGS 8'h80
// Operation codes
`define CRF_OP_NONE 5'h00
`define CRF_OP_ADD 5'h01
`define CRF_OP_ADDX 5'h02
`define CRF_OP_SUB 5'h03
`define CRF_OP_SUBX 5'h04
`define CRF_OP_CMP 5'h05
`define CRF_OP_NEG 5'h06
`define CRF_OP_AND 5'h07
`define CRF_OP_OR 5'h08
`define CRF_OP_XOR 5'h09
`define CRF_OP_MOV 5'h0a
`define CRF_OP_SHL 5'h0b
`define CRF_OP_SHR 5'h0c
`define CRF_OP_DAA 5'h0d
`define CRF_OP_DAS 5'h0e
`define CRF_OP_BLD 5'h0f
`define CRF_OP_BAND 5'h10
`define CRF_OP_BOR 5'h11
`define CRF_OP_BXOR 5'h12
`define CRF_OP_BST 5'h13
`define CRF_OP_BSET 5'h14
`define CRF_OP_BCLR 5'h15
`define CRF_OP_BNOT 5'h16
`define CRF_OP_LOAD_CTRL 5'h17
`define CRF_OP_AND_CTRL 5'h18
`define CRF_OP_OR_CTRL 5'h19
`define CRF_OP_XOR_CTRL 5'h1a
`define CRF_OP_POPC 5'h1b
`define CRF_OP_SPADJ 5'h1c
`define CRF_OP_BTST 5'h1d
`define CRF_OP_ADDS 5'h1e
// Controller states
`define CRF_ST_VEC 2'h0
`define CRF_ST_RUN 2'h1
`endif

// ---- logic/crf_gpr_mem.v ----
// Eight word general register bank with byte lanes and registered read ports
`timescale 1ns/100ps
module crf_gpr_mem (
   input wire i_clk,
   input wire i_we_hi,
   input wire i_we_lo,
   input wire [2:0] i_waddr,
   input wire [15:0] i_wdata,
   input wire [2:0] i_raddr_a,
   input wire [2:0] i_raddr_b,
   output reg [15:0] o_rdata_a,
   output reg [15:0] o_rdata_b
);
   // No reset: contents are undefined after reset, as is the stack pointer
   reg [7:0] hi_r [0:7];
   reg [7:0] lo_r [0:7];
   always @(posedge i_clk) begin
      if (i_we_hi) begin
         hi_r[i_waddr] <= i_wdata[15:8];
      end
      if (i_we_lo) begin
         lo_r[i_waddr] <= i_wdata[7:0];
      end
      o_rdata_a <= {hi_r[i_raddr_a], lo_r[i_raddr_a]};
      o_rdata_b <= {hi_r[i_raddr_b], lo_r[i_raddr_b]};
   end
endmodule
